// ===== hw/sesl_top.sv
`timescale 1ns/1ps
`include "sesl_regs.svh"

// Summary of operation
// [RL1] Eight-bit enable mask, zero after reset
// [RL2] Mask selects flags feeding event summary
// [RL3] Status bit 5 is OR of enabled flags
// [RL4] Power-on bit 7, command error bit 5
// [RL5] Exec 4, device 3, query 2, complete 0
// [RL6] Flag query returns flags and clears them
// [RL7] Clear-status zeroes flags, status; keeps masks
// [RL8] Clear-status also empties the error queue
// [RL9] Mask query returns mask unchanged
// [RL10] Parser and device errors set flags
// [RL11] Operation complete set after pending work
// [RL12] Status bit 6 is OR of enabled bits
// [RL13] Flags latch until read or cleared
// [RL14] Reset sets power-on flag, clears others
module sesl_top (
  input  wire logic                i_sys_clk,
  input  wire logic                i_nrst,
  input  wire sesl_pkg::sesl_req_t i_req,
  input  wire sesl_pkg::sesl_evt_t i_evt,
  input  wire logic                i_ops_pending,
  input  wire logic                i_oper_summary,
  input  wire logic                i_msg_avail,
  input  wire logic                i_ques_summary,
  input  wire logic                i_err_queue_nonempty,
  input  wire logic [7:0]          i_srq_enable,
  output logic                     o_resp_valid,
  output logic [7:0]               o_resp_data,
  output logic [7:0]               o_status_byte,
  output logic [7:0]               o_event_enable_mask,
  output logic                     o_err_queue_clear,
  output logic                     o_oper_clear,
  output logic                     o_ques_clear
);

  localparam logic [7:0] FLAG_USED  = `SESL_FLAG_USED;
  localparam logic [7:0] FLAG_RESET = `SESL_FLAG_RESET;

  sesl_pkg::sesl_state_t state;
  sesl_pkg::sesl_state_t next_state;

  logic [7:0] standard_event_flags;
  logic [7:0] flag_set;
  logic       flag_clr;
  logic       cmd_set_mask;
  logic       cmd_qry_mask;
  logic       cmd_qry_flags;
  logic       cmd_clr_stat;
  logic       cmd_opc;
  logic       cmd_qry_stb;
  logic       opc_done;
  logic       event_summary_bit;
  logic [7:0] stb_raw;
  logic       master_summary_bit;

  // Command decode
  always_comb begin
    cmd_set_mask  = 1'b0;
    cmd_qry_mask  = 1'b0;
    cmd_qry_flags = 1'b0;
    cmd_clr_stat  = 1'b0;
    cmd_opc       = 1'b0;
    cmd_qry_stb   = 1'b0;
    if (i_req.valid) begin
      unique case (i_req.code)
        sesl_pkg::SESL_CMD_NOP: begin
        end
        sesl_pkg::SESL_CMD_SET_MASK: begin
          cmd_set_mask = 1'b1;
        end
        sesl_pkg::SESL_CMD_QRY_MASK: begin
          cmd_qry_mask = 1'b1;
        end
        sesl_pkg::SESL_CMD_QRY_FLAGS: begin
          cmd_qry_flags = 1'b1;
        end
        sesl_pkg::SESL_CMD_CLR_STAT: begin
          cmd_clr_stat = 1'b1;
        end
        sesl_pkg::SESL_CMD_OPC: begin
          cmd_opc = 1'b1;
        end
        sesl_pkg::SESL_CMD_QRY_STB: begin
          cmd_qry_stb = 1'b1;
        end
        default: begin
        end
      endcase
    end
  end

  // Operation complete once nothing is pending
  assign opc_done = state.opc_armed && !i_ops_pending; // [RL11]

  // Event sources onto flag positions
  always_comb begin
    flag_set = 8'h00;
    flag_set[`SESL_FLAG_CMD_BIT] = i_evt.cmd_err;   // [RL4] [RL10]
    flag_set[`SESL_FLAG_EXE_BIT] = i_evt.exec_err;  // [RL5] [RL10]
    flag_set[`SESL_FLAG_DEV_BIT] = i_evt.dev_err;   // [RL5] [RL10]
    flag_set[`SESL_FLAG_QRY_BIT] = i_evt.query_err; // [RL5] [RL10]
    flag_set[`SESL_FLAG_OPC_BIT] = opc_done;        // [RL5] [RL11]
  end

  // Read-to-clear and clear-status both clear the flags
  assign flag_clr = cmd_qry_flags || cmd_clr_stat; // [RL6] [RL7]

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_flag
      if (FLAG_USED[gi]) begin : g_used
        sesl_flag_bit #(
          .RESET_VAL (FLAG_RESET[gi])
        ) u_flag (
          .i_sys_clk (i_sys_clk),
          .i_nrst    (i_nrst),
          .i_set     (flag_set[gi]),
          .i_clr     (flag_clr),
          .o_q       (standard_event_flags[gi])
        );
      end else begin : g_unused
        assign standard_event_flags[gi] = 1'b0; // [RL4] [RL5]
      end
    end
  endgenerate

  // Event summary from enabled flags
  assign event_summary_bit = |(standard_event_flags & state.mask); // [RL2] [RL3]

  // Status byte without master summary
  always_comb begin
    stb_raw = 8'h00;
    stb_raw[`SESL_STB_OPER_BIT] = i_oper_summary;
    stb_raw[`SESL_STB_ESB_BIT]  = event_summary_bit; // [RL3]
    stb_raw[`SESL_STB_MAV_BIT]  = i_msg_avail;
    stb_raw[`SESL_STB_QUES_BIT] = i_ques_summary;
    stb_raw[`SESL_STB_ERRQ_BIT] = i_err_queue_nonempty;
  end

  // Master summary over enabled status bits
  assign master_summary_bit = |(stb_raw & i_srq_enable); // [RL12]

  always_comb begin
    next_state = state;
    next_state.resp_valid      = 1'b0;
    next_state.err_queue_clear = 1'b0;
    next_state.oper_clear      = 1'b0;
    next_state.ques_clear      = 1'b0;

    // Status byte refresh
    next_state.status_byte = stb_raw;
    next_state.status_byte[`SESL_STB_MSS_BIT] = master_summary_bit; // [RL12]

    // Operation complete arming
    if (opc_done) begin
      next_state.opc_armed = 1'b0; // [RL11]
    end
    if (cmd_opc) begin
      next_state.opc_armed = 1'b1; // [RL11]
    end

    // Mask write
    if (cmd_set_mask) begin
      next_state.mask = i_req.data; // [RL1]
    end

    // Queries
    if (cmd_qry_mask) begin
      next_state.resp_valid = 1'b1;
      next_state.resp_data  = state.mask; // [RL9]
    end
    if (cmd_qry_flags) begin
      next_state.resp_valid = 1'b1;
      next_state.resp_data  = standard_event_flags; // [RL6]
    end
    if (cmd_qry_stb) begin
      next_state.resp_valid = 1'b1;
      next_state.resp_data  = state.status_byte;
    end

    // Clear status, masks untouched
    if (cmd_clr_stat) begin
      next_state.status_byte     = 8'h00; // [RL7]
      next_state.oper_clear      = 1'b1;  // [RL7]
      next_state.ques_clear      = 1'b1;  // [RL7]
      next_state.err_queue_clear = 1'b1;  // [RL8]
      next_state.opc_armed       = 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      state.mask            <= `SESL_MASK_RESET; // [RL1]
      state.opc_armed       <= 1'b0;
      state.resp_valid      <= 1'b0;
      state.resp_data       <= 8'h00;
      state.status_byte     <= `SESL_STB_RESET;
      state.err_queue_clear <= 1'b0;
      state.oper_clear      <= 1'b0;
      state.ques_clear      <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  assign o_resp_valid        = state.resp_valid;
  assign o_resp_data         = state.resp_data;
  assign o_status_byte       = state.status_byte;
  assign o_event_enable_mask = state.mask;
  assign o_err_queue_clear   = state.err_queue_clear;
  assign o_oper_clear        = state.oper_clear;
  assign o_ques_clear        = state.ques_clear;

endmodule

// ===== hw/sesl_regs.svh
`ifndef SESL_REGS_SVH
`define SESL_REGS_SVH

// Flag register bit positions
`define SESL_FLAG_OPC_BIT   0
`define SESL_FLAG_QRY_BIT   2
`define SESL_FLAG_DEV_BIT   3
`define SESL_FLAG_EXE_BIT   4
`define SESL_FLAG_CMD_BIT   5
`define SESL_FLAG_PWR_BIT   7

// Implemented flag bits, bits 6 and 1 unused
`define SESL_FLAG_USED      8'hbd

// Reset values
`define SESL_FLAG_RESET     8'h80
`define SESL_MASK_RESET     8'h00
`define SESL_STB_RESET      8'h00

// Status byte bit positions
`define SESL_STB_ERRQ_BIT   2
`define SESL_STB_QUES_BIT   3
`define SESL_STB_MAV_BIT    4
`define SESL_STB_ESB_BIT    5
`define SESL_STB_MSS_BIT    6
`define SESL_STB_OPER_BIT   7

`endif

// ===== hw/sesl_pkg.sv
package sesl_pkg;

  // Host command codes
  typedef enum logic [2:0] {
    SESL_CMD_NOP       = 3'b000,
    SESL_CMD_SET_MASK  = 3'b001,
    SESL_CMD_QRY_MASK  = 3'b010,
    SESL_CMD_QRY_FLAGS = 3'b011,
    SESL_CMD_CLR_STAT  = 3'b100,
    SESL_CMD_OPC       = 3'b101,
    SESL_CMD_QRY_STB   = 3'b110
  } sesl_cmd_t;

  // Command request carrier
  typedef struct packed {
    logic       valid;
    sesl_cmd_t  code;
    logic [7:0] data;
  } sesl_req_t;

  // Condition events from parser and device
  typedef struct packed {
    logic cmd_err;
    logic exec_err;
    logic dev_err;
    logic query_err;
  } sesl_evt_t;

  // Single sticky flag state
  typedef struct packed {
    logic q;
  } sesl_flag_state_t;

  // Top-level state
  typedef struct packed {
    logic [7:0] mask;
    logic       opc_armed;
    logic       resp_valid;
    logic [7:0] resp_data;
    logic [7:0] status_byte;
    logic       err_queue_clear;
    logic       oper_clear;
    logic       ques_clear;
  } sesl_state_t;

endpackage

// ===== hw/sesl_flag_bit.sv
`timescale 1ns/1ps

module sesl_flag_bit #(
  parameter logic RESET_VAL = 1'b0
) (
  input  wire logic i_sys_clk,
  input  wire logic i_nrst,
  input  wire logic i_set,
  input  wire logic i_clr,
  output logic      o_q
);

  sesl_pkg::sesl_flag_state_t state;
  sesl_pkg::sesl_flag_state_t next_state;

  // Set wins over clear
  always_comb begin
    next_state = state;
    if (i_clr) begin
      next_state.q = 1'b0; // [RL13]
    end
    if (i_set) begin
      next_state.q = 1'b1; // [RL13]
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      state.q <= RESET_VAL; // [RL14]
    end else begin
      state <= next_state;
    end
  end

  assign o_q = state.q;

endmodule

// ===== sim/sesl_chk.sv
`timescale 1ns/1ps
module sesl_chk (
  input wire logic                i_sys_clk,
  input wire logic                i_nrst,
  input wire sesl_pkg::sesl_req_t i_req,
  input wire logic                o_resp_valid,
  input wire logic [7:0]          o_resp_data,
  input wire logic [7:0]          o_status_byte,
  input wire logic [7:0]          o_event_enable_mask,
  input wire logic                o_err_queue_clear,
  input wire logic                o_oper_clear,
  input wire logic                o_ques_clear,
  input wire logic [7:0]          i_srq_enable
);
  logic [2:0] c;
  logic       v;
  logic       q;
  assign v = i_req.valid;
  assign c = i_req.code;
  assign q = v && (c == 3'h2 || c == 3'h3 || c == 3'h6);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);
  resp_mask_a: assert property (
    v && c == 3'h2 |=> o_resp_valid
    && o_resp_data == $past(o_event_enable_mask)) else $error("mask answer");
  mask_set_a: assert property (
    v && c == 3'h1 |=> o_event_enable_mask == $past(i_req.data))
    else $error("mask write");
  mask_keep_a: assert property (
    v && (c == 3'h2 || c == 3'h4) |=> $stable(o_event_enable_mask))
    else $error("mask changed");
  no_answer_a: assert property (!q |=> !o_resp_valid)
    else $error("stray answer");
  hold_data_a: assert property (!q |=> $stable(o_resp_data))
    else $error("answer changed");
  clr_stat_a: assert property (
    v && c == 3'h4 |=> o_status_byte == 8'h00 && o_err_queue_clear
    && o_oper_clear && o_ques_clear) else $error("clear status");
  pulse_cause_a: assert property (
    o_err_queue_clear |-> $past(v && c == 3'h4)) else $error("stray clear");
  esb_off_a: assert property (
    o_event_enable_mask == 8'h00 |=> !o_status_byte[5])
    else $error("summary set");
  mss_sum_a: assert property (
    o_status_byte[6] == |({o_status_byte[7], 1'b0, o_status_byte[5:0]}
    & $past(i_srq_enable))) else $error("master summary");
endmodule

bind sesl_top sesl_chk i_chk (.i_sys_clk, .i_nrst, .i_req, .o_resp_valid,
  .o_resp_data, .o_status_byte, .o_event_enable_mask, .o_err_queue_clear,
  .o_oper_clear, .o_ques_clear, .i_srq_enable);

// ===== sim/sesl_host_model.sv
`timescale 1ns/1ps
module sesl_host_model (
  input  wire logic           i_sys_clk,
  output sesl_pkg::sesl_req_t o_req,
  output sesl_pkg::sesl_evt_t o_evt
);
  initial begin
    o_req = '0;
    o_evt = '0;
  end
  // One command per cycle
  task automatic cmd(input logic [2:0] c, input logic [7:0] d);
    @(negedge i_sys_clk);
    o_req <= {1'b1, c, d};
  endtask
  // Released data shows inverse
  task automatic idle();
    @(negedge i_sys_clk);
    o_req <= {1'b0, o_req.code, ~o_req.data};
  endtask
  task automatic ev(input logic [3:0] e);
    @(negedge i_sys_clk);
    o_evt <= e;
    @(negedge i_sys_clk);
    o_evt <= '0;
  endtask
endmodule

// ===== sim/sesl_top_tb.sv
`timescale 1ns/1ps
module sesl_top_tb;
  logic                clk;
  logic                nrst;
  logic                pend;
  logic [3:0]          st;
  logic [7:0]          srq;
  sesl_pkg::sesl_req_t req;
  sesl_pkg::sesl_evt_t evt;
  logic                rv;
  logic                eqc;
  logic [7:0]          rdd;
  logic [7:0]          stb;
  int                  error_cnt;
  int                  total_checks;
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  sesl_host_model i_host (.i_sys_clk(clk), .o_req(req), .o_evt(evt));
  sesl_top i_dut (.i_sys_clk(clk), .i_nrst(nrst), .i_req(req), .i_evt(evt),
    .i_ops_pending(pend), .i_oper_summary(st[3]), .i_msg_avail(st[2]),
    .i_ques_summary(st[1]), .i_err_queue_nonempty(st[0]),
    .i_srq_enable(srq), .o_resp_valid(rv), .o_resp_data(rdd),
    .o_status_byte(stb), .o_event_enable_mask(),
    .o_err_queue_clear(eqc), .o_oper_clear(), .o_ques_clear());
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [2:0] c, input logic [7:0] exp);
    i_host.cmd(c, 8'h00);
    i_host.idle();
    chk({7'h00, rv}, 8'h01);
    chk(rdd, exp);
  endtask
  task automatic wt(input int n);
    repeat (n) i_host.idle();
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    #20000;
    error_cnt++;
    final_report();
  end
  initial begin
    nrst = 1'b0;
    pend = 1'b0;
    st = 4'h0;
    srq = 8'h00;
    error_cnt = 0;
    total_checks = 0;
    repeat (12) @(negedge clk);
    nrst = 1'b1;
    rd(3'h2, 8'h00);
    rd(3'h3, 8'h80);
    rd(3'h3, 8'h00);
    fork
      begin
        i_host.cmd(3'h3, 8'h00);
        i_host.idle();
      end
      i_host.ev(4'h1);
    join
    chk({7'h00, rv}, 8'h01);
    chk(rdd, 8'h00);
    rd(3'h3, 8'h04);
    for (int i = 0; i < 4; i++) begin
      i_host.ev(4'h1 << i);
      rd(3'h3, 8'h04 << i);
    end
    i_host.ev(4'hf);
    wt(3);
    rd(3'h3, 8'h3c);
    i_host.cmd(3'h1, 8'hff);
    i_host.idle();
    i_host.ev(4'h8);
    wt(2);
    chk(stb, 8'h20);
    i_host.cmd(3'h0, 8'h55);
    i_host.cmd(3'h7, 8'h55);
    rd(3'h2, 8'hff);
    i_host.cmd(3'h1, 8'h1f);
    wt(3);
    chk(stb, 8'h00);
    st = 4'h4;
    i_host.cmd(3'h4, 8'h00);
    chk(stb, 8'h10);
    i_host.idle();
    chk({7'h00, eqc}, 8'h01);
    chk(stb, 8'h00);
    st = 4'h0;
    rd(3'h3, 8'h00);
    rd(3'h2, 8'h1f);
    pend = 1'b1;
    i_host.cmd(3'h5, 8'h00);
    rd(3'h3, 8'h00);
    wt(3);
    rd(3'h3, 8'h00);
    pend = 1'b0;
    wt(2);
    rd(3'h3, 8'h01);
    st = 4'h8;
    srq = 8'h80;
    wt(3);
    chk(stb, 8'hc0);
    rd(3'h6, 8'hc0);
    final_report();
  end
endmodule
